// File: hdl/ioxp_pkg.sv
// Constants for the four-bit I2C port expander target.
// Assumes a single 100 MHz system clock and pins sampled through synchronisers.
package ioxp_pkg;
   localparam logic [6:0] IOXP_TARGET_ADDR = 7'h41;
   localparam logic [6:0] IOXP_GCALL_ADDR  = 7'h00;
   localparam logic [7:0] IOXP_GCALL_RESET = 8'h06;
   localparam logic [7:0] IOXP_CMD_INPUT   = 8'h00;
   localparam logic [7:0] IOXP_CMD_OUTPUT  = 8'h01;
   localparam logic [7:0] IOXP_CMD_INVERT  = 8'h02;
   localparam logic [7:0] IOXP_CMD_DIR     = 8'h03;
   localparam logic [7:0] IOXP_CMD_SPECIAL = 8'h50;
   localparam logic [7:0] IOXP_RST_OUTPUT  = 8'hff;
   localparam logic [7:0] IOXP_RST_INVERT  = 8'h00;
   localparam logic [7:0] IOXP_RST_DIR     = 8'hff;
   localparam logic [7:0] IOXP_RST_SPECIAL = 8'h00;
   localparam logic [7:0] IOXP_RST_CMD     = 8'h00;
   localparam logic [7:0] IOXP_UNMAPPED    = 8'hff;
   localparam logic [3:0] IOXP_INPUT_UPPER = 4'hf;
   localparam int         IOXP_BIT_IRQSEL  = 7;
   localparam int         IOXP_BIT_PULLOFF = 6;
   localparam int         IOXP_PIN_IRQ     = 3;
   localparam logic [2:0] IOXP_LAST_BIT    = 3'h7;
endpackage : ioxp_pkg

// File: hdl/ioxp_top.sv
// I2C target of a four-bit port expander with registers and software reset.
// Assumes SCL/SDA and port pins are asynchronous; the pad resolves the enables.
`timescale 1ns/1ps
module ioxp_top #(
   parameter int NPINS = 4
) (
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic             scl_in,
   input  wire logic             sda_in,
   output logic                  sda_oe,
   input  wire logic [NPINS-1:0] port_in,
   output logic      [NPINS-1:0] port_out,
   output logic      [NPINS-1:0] port_oe,
   output logic      [NPINS-1:0] pullup_en
);
   typedef enum {IOXP_IDLE, IOXP_ADDR, IOXP_ADDR_ACK, IOXP_WDATA, IOXP_WACK,
                 IOXP_RDATA, IOXP_RACK, IOXP_IGNORE} ioxp_state_type;

   // Elaboration check: the register fields hard-wire four pins
   if (NPINS != 4) begin : g_npins_check
      $error("ioxp_top serves exactly four pins");
   end

   ioxp_state_type state;
   logic [1:0] scl_sync, sda_sync, bus_seen;
   logic [NPINS-1:0] pin_meta, pin_sync;
   logic [7:0] shifter, tx_byte, cmd, output_latch, input_invert_mask;
   logic [7:0] pin_direction, pin3_and_pullup_control, pin_level_readback;
   logic [2:0] bit_cnt;
   logic       is_read, is_gcall, byte_index, gc_armed, addr_match, ack_drive;
   logic       soft_reset, irq_flag;
   logic [NPINS-1:0] irq_ref;
   logic       scl_rise, scl_fall, start_cond, stop_cond, read_input_ack;
   logic [3:0] sensed;
   logic [7:0] read_byte;

   // Two-flop synchronisers; only the second stage and the history are read
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         bus_seen <= 2'h3;
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         scl_sync <= {scl_sync[0], scl_in};
         sda_sync <= {sda_sync[0], sda_in};
         bus_seen <= {scl_sync[1], sda_sync[1]};
         pin_meta <= port_in;
         pin_sync <= pin_meta;
      end
   end

   // Bus events from the synchronised lines, compared with last cycle
   assign scl_rise   = scl_sync[1] && !bus_seen[1];
   assign scl_fall   = !scl_sync[1] && bus_seen[1];
   assign start_cond = scl_sync[1] && bus_seen[1] && !sda_sync[1] && bus_seen[0];
   assign stop_cond  = scl_sync[1] && bus_seen[1] && sda_sync[1] && !bus_seen[0];

   // Input register is pin level XOR invert bit, upper nibble ones
   assign sensed = pin_sync ^ input_invert_mask[3:0];
   assign pin_level_readback = {ioxp_pkg::IOXP_INPUT_UPPER, sensed};

   // Read source always follows the stored selection
   function automatic logic [7:0] read_mux(input logic [7:0] sel);
      if (sel == ioxp_pkg::IOXP_CMD_INPUT) read_mux = pin_level_readback;
      else if (sel == ioxp_pkg::IOXP_CMD_OUTPUT) read_mux = output_latch;
      else if (sel == ioxp_pkg::IOXP_CMD_INVERT) read_mux = input_invert_mask;
      else if (sel == ioxp_pkg::IOXP_CMD_DIR) read_mux = pin_direction;
      else if (sel == ioxp_pkg::IOXP_CMD_SPECIAL) read_mux = pin3_and_pullup_control;
      else read_mux = ioxp_pkg::IOXP_UNMAPPED;
   endfunction : read_mux

   // Byte to send next; always_comb also follows the registers read inside the mux
   always_comb begin
      read_byte = read_mux(cmd);
   end

   // Address decision on the eighth bit: own address or write-only General Call
   always_comb begin
      addr_match = 1'b0;
      if ({shifter[6:0], sda_sync[1]} == {ioxp_pkg::IOXP_TARGET_ADDR, 1'b0} ||
          {shifter[6:0], sda_sync[1]} == {ioxp_pkg::IOXP_TARGET_ADDR, 1'b1}) begin
         addr_match = 1'b1;
      end else if ({shifter[6:0], sda_sync[1]} == {ioxp_pkg::IOXP_GCALL_ADDR, 1'b0}) begin
         addr_match = 1'b1; // read-bit General Call falls through unanswered
      end
   end

   // Input read's acknowledge clock clears the interrupt, whether the controller sends ACK or NACK
   assign read_input_ack = (state == IOXP_RACK) && scl_rise && !is_gcall &&
                           (cmd == ioxp_pkg::IOXP_CMD_INPUT);

   // Protocol engine; bytes shift on SCL rise, SDA changes after SCL fall
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state      <= IOXP_IDLE;
         shifter    <= '0;
         bit_cnt    <= '0;
         is_read    <= 1'b0;
         is_gcall   <= 1'b0;
         byte_index <= 1'b0;
         gc_armed   <= 1'b0;
         ack_drive  <= 1'b0;
         tx_byte    <= '0;
         soft_reset <= 1'b0;
      end else begin
         soft_reset <= 1'b0;
         if (stop_cond) begin
            // Reset only on a stop after exactly one 0x06 byte
            soft_reset <= gc_armed;
            gc_armed   <= 1'b0;
            state      <= IOXP_IDLE;
            ack_drive  <= 1'b0;
         end else if (start_cond) begin
            // Repeated start drops a pending General Call reset
            gc_armed  <= 1'b0;
            state     <= IOXP_ADDR;
            bit_cnt   <= '0;
            ack_drive <= 1'b0;
         end else begin
            case (state)
               IOXP_IDLE, IOXP_IGNORE: begin
                  ack_drive <= 1'b0;
               end
               IOXP_ADDR: begin
                  if (scl_rise) begin
                     shifter <= {shifter[6:0], sda_sync[1]};
                     bit_cnt <= bit_cnt + 3'h1;
                     if (bit_cnt == ioxp_pkg::IOXP_LAST_BIT) begin
                        is_read    <= sda_sync[1];
                        is_gcall   <= (shifter[6:0] == ioxp_pkg::IOXP_GCALL_ADDR);
                        byte_index <= 1'b0;
                        // Other targets' traffic is ignored entirely
                        state <= addr_match ? IOXP_ADDR_ACK : IOXP_IGNORE;
                     end
                  end
               end
               IOXP_ADDR_ACK: begin
                  if (scl_fall && !ack_drive) begin
                     ack_drive <= 1'b1;
                  end else if (scl_fall) begin
                     bit_cnt <= '0;
                     if (is_read) begin
                        tx_byte   <= read_byte << 1;
                        ack_drive <= !read_byte[7];
                        state     <= IOXP_RDATA;
                     end else begin
                        ack_drive <= 1'b0;
                        state     <= IOXP_WDATA;
                     end
                  end
               end
               IOXP_WDATA: begin
                  if (scl_rise) begin
                     shifter <= {shifter[6:0], sda_sync[1]};
                     bit_cnt <= bit_cnt + 3'h1;
                  end else if (scl_fall && bit_cnt == 3'h0) begin
                     // Eighth bit in: answer per policy, a refused byte ends the message
                     ack_drive <= ack_pending(is_gcall, byte_index, shifter);
                     state     <= ack_pending(is_gcall, byte_index, shifter) ? IOXP_WACK
                                                                               : IOXP_IGNORE;
                     if (is_gcall) begin
                        // Second General Call byte kills the message
                        gc_armed <= !byte_index && (shifter == ioxp_pkg::IOXP_GCALL_RESET);
                     end
                  end
               end
               IOXP_WACK: begin
                  if (scl_fall) begin
                     ack_drive  <= 1'b0;
                     byte_index <= 1'b1;
                     bit_cnt    <= '0;
                     state      <= IOXP_WDATA;
                  end
               end
               IOXP_RDATA: begin
                  if (scl_fall) begin
                     bit_cnt <= bit_cnt + 3'h1;
                     if (bit_cnt == ioxp_pkg::IOXP_LAST_BIT) begin
                        ack_drive <= 1'b0;
                        state     <= IOXP_RACK;
                     end else begin
                        ack_drive <= !tx_byte[7];
                        tx_byte   <= tx_byte << 1;
                     end
                  end
               end
               IOXP_RACK: begin
                  if (scl_rise && sda_sync[1]) begin
                     // Controller NACK ends the read
                     state <= IOXP_IGNORE;
                  end else if (scl_fall) begin
                     // Controller ACK: reload the same register, no increment
                     bit_cnt   <= '0;
                     tx_byte   <= read_byte << 1;
                     ack_drive <= !read_byte[7];
                     state     <= IOXP_RDATA;
                  end
               end
               default: state <= IOXP_IDLE;
            endcase
         end
      end
   end

   // Acknowledge policy for written bytes; General Call takes only one 0x06
   function automatic logic ack_pending(input logic gc, input logic idx,
                                        input logic [7:0] b);
      if (gc) ack_pending = !idx && (b == ioxp_pkg::IOXP_GCALL_RESET);
      else ack_pending = 1'b1;
   endfunction : ack_pending

   // Register writes, taken as the acknowledge clock rises
   always_ff @(posedge clock) begin
      if (!rst_n || soft_reset) begin
         cmd                     <= ioxp_pkg::IOXP_RST_CMD;
         output_latch            <= ioxp_pkg::IOXP_RST_OUTPUT;
         input_invert_mask       <= ioxp_pkg::IOXP_RST_INVERT;
         pin_direction           <= ioxp_pkg::IOXP_RST_DIR;
         pin3_and_pullup_control <= ioxp_pkg::IOXP_RST_SPECIAL;
      end else if (state == IOXP_WACK && scl_rise && !is_gcall) begin
         if (!byte_index) begin
            cmd <= shifter;
         end else if (cmd == ioxp_pkg::IOXP_CMD_OUTPUT) begin
            output_latch <= shifter;
         end else if (cmd == ioxp_pkg::IOXP_CMD_INVERT) begin
            input_invert_mask <= shifter;
         end else if (cmd == ioxp_pkg::IOXP_CMD_DIR) begin
            pin_direction <= shifter;
         end else if (cmd == ioxp_pkg::IOXP_CMD_SPECIAL) begin
            pin3_and_pullup_control <= shifter;
         end
         // Input register and unknown selections absorb the write
      end
   end

   // Interrupt reference follows the pins while quiet or out of interrupt mode, so
   // reset or mode entry raises no false edge; an input read reloads it
   always_ff @(posedge clock) begin
      if (!rst_n || soft_reset) begin
         irq_ref <= '0;
      end else if (read_input_ack || !irq_flag ||
                   !pin3_and_pullup_control[ioxp_pkg::IOXP_BIT_IRQSEL]) begin
         irq_ref <= pin_sync;
      end
   end

   // Flag raised while any input pin differs; output pins and pin 3 in interrupt mode are masked
   always_comb begin
      irq_flag = 1'b0;
      for (int i = 0; i < NPINS; i++) begin
         if (pin_direction[i] && !(i == ioxp_pkg::IOXP_PIN_IRQ &&
             pin3_and_pullup_control[ioxp_pkg::IOXP_BIT_IRQSEL])) begin
            irq_flag = irq_flag | (pin_sync[i] != irq_ref[i]);
         end
      end
   end

   // Pin drivers; pin three becomes open-drain active-low interrupt
   always_comb begin
      for (int i = 0; i < NPINS; i++) begin
         port_out[i]  = output_latch[i];
         port_oe[i]   = !pin_direction[i];
         pullup_en[i] = !pin3_and_pullup_control[ioxp_pkg::IOXP_BIT_PULLOFF];
      end
      if (pin3_and_pullup_control[ioxp_pkg::IOXP_BIT_IRQSEL]) begin
         port_out[ioxp_pkg::IOXP_PIN_IRQ] = 1'b0;
         port_oe[ioxp_pkg::IOXP_PIN_IRQ]  = irq_flag;
      end
   end

   assign sda_oe = ack_drive;

   chk_gcall_read_nack: assert property (@(posedge clock) disable iff (!rst_n)
      (state == IOXP_ADDR && scl_rise && bit_cnt == ioxp_pkg::IOXP_LAST_BIT &&
       shifter[6:0] == ioxp_pkg::IOXP_GCALL_ADDR && sda_sync[1]) |=> state == IOXP_IGNORE)
      else $error("General Call read was answered");
   chk_reset_on_stop: assert property (@(posedge clock) disable iff (!rst_n)
      soft_reset |-> $past(stop_cond))
      else $error("Software reset without stop");
   chk_reset_defaults: assert property (@(posedge clock) disable iff (!rst_n)
      soft_reset |=> pin_direction == ioxp_pkg::IOXP_RST_DIR && port_oe == '0)
      else $error("Software reset left a pin driven");
   chk_input_upper: assert property (@(posedge clock)
      pin_level_readback[7:4] == ioxp_pkg::IOXP_INPUT_UPPER)
      else $error("Input upper bits not ones");
   chk_input_pins_hiz: assert property (@(posedge clock) disable iff (!rst_n)
      pin_direction[0] |-> !port_oe[0])
      else $error("Input pin driven");
   chk_pullup_off: assert property (@(posedge clock) disable iff (!rst_n)
      pin3_and_pullup_control[ioxp_pkg::IOXP_BIT_PULLOFF] |-> pullup_en == '0)
      else $error("Pull-up left on");
   chk_cmd_holds: assert property (@(posedge clock) disable iff (!rst_n)
      (state != IOXP_WACK && !soft_reset) |=> $stable(cmd))
      else $error("Selection changed outside a write");
   chk_irq_pin_low: assert property (@(posedge clock) disable iff (!rst_n)
      (pin3_and_pullup_control[ioxp_pkg::IOXP_BIT_IRQSEL] && irq_flag) |->
      port_oe[ioxp_pkg::IOXP_PIN_IRQ] && !port_out[ioxp_pkg::IOXP_PIN_IRQ])
      else $error("Interrupt not driven low");

   // Protocol steps shared by the checks below; each names one bus event
   sequence seq_own_addr_seen;
      state == IOXP_ADDR && scl_rise && bit_cnt == ioxp_pkg::IOXP_LAST_BIT &&
      shifter[6:0] == ioxp_pkg::IOXP_TARGET_ADDR;
   endsequence
   sequence seq_reset_armed_stop;
      gc_armed && stop_cond;
   endsequence
   sequence seq_output_ack_rise;
      state == IOXP_WACK && scl_rise && !is_gcall && byte_index &&
      cmd == ioxp_pkg::IOXP_CMD_OUTPUT;
   endsequence
   sequence seq_next_read_byte;
      state == IOXP_RACK && scl_fall;
   endsequence
   sequence seq_gc_extra_byte;
      state == IOXP_WDATA && is_gcall && byte_index && scl_fall &&
      bit_cnt == 3'h0;
   endsequence

   // Soft reset takes two cycles after the stop: the flag first, registers next
   chk_own_addr_taken: assert property (@(posedge clock) disable iff (!rst_n)
      seq_own_addr_seen |=> state == IOXP_ADDR_ACK)
      else $error("Own address not taken");
   chk_soft_reset_seq: assert property (@(posedge clock) disable iff (!rst_n)
      seq_reset_armed_stop |=> soft_reset ##1 (output_latch == ioxp_pkg::IOXP_RST_OUTPUT &&
      pin3_and_pullup_control == ioxp_pkg::IOXP_RST_SPECIAL))
      else $error("Armed stop gave no reset");
   chk_latch_on_ack: assert property (@(posedge clock) disable iff (!rst_n)
      seq_output_ack_rise |=> output_latch == $past(shifter))
      else $error("Output byte not latched at acknowledge");
   chk_read_same_reg: assert property (@(posedge clock) disable iff (!rst_n)
      seq_next_read_byte |=> state == IOXP_RDATA && tx_byte == ($past(read_byte) << 1))
      else $error("Further read byte changed source");
   chk_gcall_extra_drop: assert property (@(posedge clock) disable iff (!rst_n)
      seq_gc_extra_byte |=> state == IOXP_IGNORE && !gc_armed)
      else $error("Extra General Call byte kept");
   chk_ignore_no_ack: assert property (@(posedge clock) disable iff (!rst_n)
      state == IOXP_IGNORE |-> !sda_oe)
      else $error("Refused traffic answered");
   chk_restart_disarms: assert property (@(posedge clock) disable iff (!rst_n)
      start_cond |=> !gc_armed)
      else $error("Repeated start kept reset armed");
endmodule : ioxp_top

// File: test/ioxp_bus_ctl.sv
// Bus controller model: drives SCL and SDA as open-drain lines with pull-ups.
// Assumes one caller at a time, entering each task just after a clock edge.
`timescale 1ns/1ps
module ioxp_bus_ctl (
   input  wire logic clock,
   input  wire logic sda_oe,
   output logic      scl_line,
   output logic      sda_line
);
   localparam int HALF = 10;
   logic scl_low = 1'b0;
   logic sda_low = 1'b0;
   // Released lines float high through the pull-ups
   assign scl_line = ~scl_low;
   assign sda_line = ~(sda_low | sda_oe);
   // One SCL pulse; 10-cycle phases stay clear of the 4-cycle minimum
   task automatic pulse(output logic seen);
      repeat (HALF) @(posedge clock);
      scl_low <= 1'b0;
      repeat (HALF) @(posedge clock);
      seen = sda_line; // Late in the high phase, where SDA has settled
      scl_low <= 1'b1;
      repeat (3) @(posedge clock);
   endtask : pulse
   // Start or repeated start: SDA falls while SCL is high
   task automatic start_cond();
      sda_low <= 1'b0;
      repeat (3) @(posedge clock);
      scl_low <= 1'b0;
      repeat (HALF) @(posedge clock);
      sda_low <= 1'b1;
      repeat (HALF) @(posedge clock);
      scl_low <= 1'b1;
      repeat (3) @(posedge clock);
   endtask : start_cond
   // Stop: SDA rises while SCL is high, ending any transfer
   task automatic stop_cond();
      sda_low <= 1'b1;
      repeat (3) @(posedge clock);
      scl_low <= 1'b0;
      repeat (HALF) @(posedge clock);
      sda_low <= 1'b0;
      repeat (HALF) @(posedge clock);
   endtask : stop_cond
   // Byte out MSB first, then the target's acknowledge is sampled
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic seen;
      for (int i = 7; i >= 0; i--) begin
         sda_low <= ~b[i];
         pulse(seen);
      end
      sda_low <= 1'b0;
      pulse(seen);
      ack = ~seen;
   endtask : send_byte
   // Byte in; acknowledge withheld on the last one wanted
   task automatic recv_byte(input logic last, output logic [7:0] b);
      logic seen;
      sda_low <= 1'b0;
      for (int i = 7; i >= 0; i--) begin
         pulse(seen);
         b[i] = seen;
      end
      sda_low <= ~last;
      pulse(seen);
   endtask : recv_byte
endmodule : ioxp_bus_ctl

// File: test/tb_i2c_four_bit_io_expander.sv
// Testbench for the port expander target: register access and soft reset.
// Assumes pins are driven by the bench wherever the design does not drive.
`timescale 1ns/1ps
module tb_i2c_four_bit_io_expander;
   logic       clock;
   logic       rst_n = 1'b0;
   logic       scl_in = 1'b1;
   logic       sda_in = 1'b1;
   logic [3:0] port_in = 4'hf;
   logic [3:0] ext_val = 4'ha;
   logic       sda_oe;
   logic [3:0] port_out;
   logic [3:0] port_oe;
   logic [3:0] pullup_en;
   logic       scl_line;
   logic       sda_line;
   int         mismatches = 0;
   int         total_checks = 0;
   logic [7:0] rd;
   ioxp_top #(.NPINS(4)) ioxp_top_i (.clock(clock), .rst_n(rst_n), .scl_in(scl_in),
      .sda_in(sda_in), .sda_oe(sda_oe), .port_in(port_in), .port_out(port_out),
      .port_oe(port_oe), .pullup_en(pullup_en));
   ioxp_bus_ctl ioxp_bus_ctl_i (.clock(clock), .sda_oe(sda_oe), .scl_line(scl_line),
      .sda_line(sda_line));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Pads: a driven pin shows the design's level, otherwise the outside one
   always @(posedge clock) begin
      scl_in <= scl_line;
      sda_in <= sda_line;
      port_in <= (port_oe & port_out) | (~port_oe & ext_val);
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : give_verdict
   // Sends a byte and compares the acknowledge with the one expected
   task automatic put(input logic [7:0] b, input logic exp_ack);
      logic ack;
      ioxp_bus_ctl_i.send_byte(b, ack);
      check({7'h00, ack}, {7'h00, exp_ack});
   endtask : put
   task automatic wr_reg(input logic [7:0] cmd, input logic [7:0] val);
      logic ack;
      ioxp_bus_ctl_i.start_cond();
      put({ioxp_pkg::IOXP_TARGET_ADDR, 1'b0}, 1'b1);
      put(cmd, 1'b1);
      ioxp_bus_ctl_i.send_byte(val, ack); // Data acknowledge unchecked; every selection acknowledges
      ioxp_bus_ctl_i.stop_cond();
   endtask : wr_reg
   // Reads n bytes; every byte after the first must repeat it
   task automatic rd_reg(input logic send_cmd, input logic [7:0] cmd, input int n,
                         output logic [7:0] val);
      logic [7:0] first;
      if (send_cmd) begin
         ioxp_bus_ctl_i.start_cond();
         put({ioxp_pkg::IOXP_TARGET_ADDR, 1'b0}, 1'b1);
         put(cmd, 1'b1);
      end
      ioxp_bus_ctl_i.start_cond();
      put({ioxp_pkg::IOXP_TARGET_ADDR, 1'b1}, 1'b1);
      for (int k = 1; k <= n; k++) begin
         ioxp_bus_ctl_i.recv_byte(k == n, val);
         if (k == 1) first = val;
         else check(val, first);
      end
      ioxp_bus_ctl_i.stop_cond();
   endtask : rd_reg
   task automatic sc_defaults();
      logic [7:0] cmds[4] = '{8'h01, 8'h02, 8'h03, 8'h50};
      logic [7:0] exps[4] = '{8'hff, 8'h00, 8'hff, 8'h00};
      check({port_oe, pullup_en}, 8'h0f);
      for (int i = 0; i < 4; i++) begin
         rd_reg(1'b1, cmds[i], 1, rd);
         check(rd, exps[i]);
      end
      rd_reg(1'b1, 8'h00, 2, rd);
      check(rd, 8'hfa);
   endtask : sc_defaults
   task automatic sc_output();
      wr_reg(8'h01, 8'h05);
      check({port_oe, port_out}, 8'h05);
      wr_reg(8'h03, 8'h00);
      check({port_oe, port_out}, 8'hf5);
      ioxp_bus_ctl_i.start_cond(); // Stop after the command byte alone
      put({ioxp_pkg::IOXP_TARGET_ADDR, 1'b0}, 1'b1);
      put(8'h01, 1'b1);
      ioxp_bus_ctl_i.stop_cond();
      check({4'h0, port_out}, 8'h05);
      rd_reg(1'b0, 8'h00, 3, rd);
      check(rd, 8'h05);
      rd_reg(1'b1, 8'h00, 1, rd);
      check(rd, 8'hf5);
      wr_reg(8'h00, 8'h33);
      rd_reg(1'b0, 8'h00, 1, rd);
      check(rd, 8'hf5);
   endtask : sc_output
   task automatic sc_invert();
      wr_reg(8'h03, 8'hff);
      wr_reg(8'h02, 8'h03);
      rd_reg(1'b1, 8'h00, 1, rd);
      check(rd, 8'hf9);
      wr_reg(8'h02, 8'h00);
   endtask : sc_invert
   task automatic sc_misc();
      ioxp_bus_ctl_i.start_cond();
      put({7'h42, 1'b0}, 1'b0);
      ioxp_bus_ctl_i.stop_cond();
      wr_reg(8'h07, 8'h00);
      rd_reg(1'b1, 8'h07, 1, rd);
      check(rd, ioxp_pkg::IOXP_UNMAPPED);
      rd_reg(1'b1, 8'h01, 1, rd);
      check(rd, 8'h05);
   endtask : sc_misc
   // General Call: rw, data byte, an extra byte, or a repeated start before the stop
   task automatic gcall(input logic rw, input logic [7:0] d, input logic extra,
                        input logic rstart);
      ioxp_bus_ctl_i.start_cond();
      put({ioxp_pkg::IOXP_GCALL_ADDR, rw}, ~rw);
      if (!rw) put(d, d == 8'h06);
      if (extra) put(8'h06, 1'b0);
      if (rstart) begin
         ioxp_bus_ctl_i.start_cond();
         put({7'h42, 1'b0}, 1'b0);
      end
      ioxp_bus_ctl_i.stop_cond();
   endtask : gcall
   task automatic sc_gcall();
      wr_reg(8'h03, 8'h00);
      wr_reg(8'h50, 8'h40);
      check({4'h0, pullup_en}, 8'h00);
      gcall(1'b1, 8'h06, 1'b0, 1'b0);
      gcall(1'b0, 8'h07, 1'b0, 1'b0);
      gcall(1'b0, 8'h06, 1'b1, 1'b0);
      gcall(1'b0, 8'h06, 1'b0, 1'b1);
      check({port_oe, pullup_en}, 8'hf0);
      gcall(1'b0, 8'h06, 1'b0, 1'b0);
      check({port_oe, pullup_en}, 8'h0f);
      rd_reg(1'b1, 8'h03, 1, rd);
      check(rd, 8'hff);
   endtask : sc_gcall
   // Pin 3 as interrupt; the pin sync needs a few cycles before it shows
   task automatic sc_irq();
      wr_reg(8'h50, 8'hc0);
      check({pullup_en, port_oe[3], port_out[3], 2'b00}, 8'h00);
      ext_val <= 4'hb;
      repeat (10) @(posedge clock);
      check({7'h00, port_oe[3]}, 8'h01);
      ext_val <= 4'ha;
      repeat (10) @(posedge clock);
      check({7'h00, port_oe[3]}, 8'h00);
      ext_val <= 4'hb;
      repeat (10) @(posedge clock);
      rd_reg(1'b1, 8'h00, 1, rd);
      check({7'h00, port_oe[3]}, 8'h00);
      wr_reg(8'h03, 8'h0d);
      wr_reg(8'h01, 8'h0d);
      repeat (10) @(posedge clock);
      check({7'h00, port_oe[3]}, 8'h00);
   endtask : sc_irq
   // Watchdog: a hang counts as a mismatch
   initial begin
      repeat (100000) @(posedge clock);
      mismatches++;
      give_verdict();
   end
   initial begin
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      repeat (4) @(posedge clock);
      sc_defaults();
      sc_output();
      sc_invert();
      sc_misc();
      sc_gcall();
      sc_irq();
      give_verdict();
   end
endmodule : tb_i2c_four_bit_io_expander
